// file: hdl/timer_pkg.sv
// Constants, types and register map of the timer register block
//
// How it works
// [RULE1] Per-channel compare C register, readable anytime
// [RULE2] Status read clears that channel's event flags
// [RULE3] Bit 18 mirrors line B level
// [RULE4] Bit 17 mirrors line A level
// [RULE5] Bit 16 shows live counter clock state
// [RULE6] Bit 7 latches external trigger until read
// [RULE7] Bit 6 latches capture B load (capture)
// [RULE8] Bit 5 latches capture A load (capture)
// [RULE9] Bit 4 latches compare C match, any mode
// [RULE10] Bit 3 latches compare B match (waveform)
// [RULE11] Bit 2 latches compare A match (waveform)
// [RULE12] Bit 1 latches double load without read
// [RULE13] Bit 0 latches counter overflow until read
// [RULE14] Enable-set write ones set mask bits
// [RULE15] Enable-clear write ones clear mask bits
// [RULE16] Mask readback shows enables, resets disabled
// [RULE17] Group trigger bit 0 pulses all channels
// [RULE18] Clock 2 routes pin2, none, A0, A1
// [RULE19] Clock 1 routes pin1, none, A0, A2
// [RULE20] Clock 0 routes pin0, none, A1, A2
// [RULE21] Mode bit one waveform, zero capture
// [RULE22] Channel irq when flag and mask set
// [RULE23] Selectors at 5:4, 3:2, 1:0; rest zero
package timer_pkg;

   localparam int NUM_CH = 3;

   // ---------------------------------------------
   // Register offsets
   // ---------------------------------------------
   localparam logic [5:0] OFS_CAP_A      = 6'h14;
   localparam logic [5:0] OFS_CAP_B      = 6'h18;
   localparam logic [5:0] OFS_CMP_C      = 6'h1C;
   localparam logic [5:0] OFS_STATUS     = 6'h20;
   localparam logic [5:0] OFS_IRQ_SET    = 6'h24;
   localparam logic [5:0] OFS_IRQ_CLR    = 6'h28;
   localparam logic [5:0] OFS_IRQ_STATE  = 6'h2C;
   localparam logic [7:0] OFS_GROUP_TRIG = 8'hC0;
   localparam logic [7:0] OFS_CLK_ROUTE  = 8'hC4;

   // ---------------------------------------------
   // Field positions
   // ---------------------------------------------
   localparam int BIT_WRAP     = 0;
   localparam int BIT_OVERRUN  = 1;
   localparam int BIT_MATCH_A  = 2;
   localparam int BIT_MATCH_B  = 3;
   localparam int BIT_MATCH_C  = 4;
   localparam int BIT_LOAD_A   = 5;
   localparam int BIT_LOAD_B   = 6;
   localparam int BIT_EXT_TRIG = 7;
   localparam int BIT_CLOCK_ON = 16;
   localparam int BIT_LINE_A   = 17;
   localparam int BIT_LINE_B   = 18;
   localparam int BIT_SYNC     = 0;
   localparam int XC0_LSB      = 0;
   localparam int XC1_LSB      = 2;
   localparam int XC2_LSB      = 4;

   // ---------------------------------------------
   // Reset values
   // ---------------------------------------------
   localparam logic [15:0] CMP_C_RST = 16'h0000;
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [7:0]  MASK_RST  = 8'h00;
   localparam logic [5:0]  ROUTE_RST = 6'h00;

   // External clock selector codes
   typedef enum logic [1:0] {
      SRC_PIN     = 2'h0,
      SRC_NONE    = 2'h1,
      SRC_LINE_LO = 2'h2,
      SRC_LINE_HI = 2'h3
   } clk_src_t;

   // Per-channel inputs from the counter core
   typedef struct packed {
      logic wave_mode;
      logic clock_on;
      logic line_a;
      logic line_b;
      logic ext_trigger;
      logic load_a;
      logic load_b;
      logic match_a;
      logic match_b;
      logic match_c;
      logic wrap;
   } chan_evt_t;

endpackage

// file: hdl/timer_status_irq_block_ctrl.sv
// Register side of a three-channel timer: compare C, flags, masks, routing
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
module timer_status_irq_block_ctrl (
   input  wire logic                                  mclk_in,
   input  wire logic                                  resetn_in,
   input  wire logic [7:0]                            addr_in,
   input  wire logic [31:0]                           wdata_in,
   input  wire logic                                  wr_in,
   input  wire logic                                  rd_in,
   output logic      [31:0]                           rdata_out,
   input  wire timer_pkg::chan_evt_t [timer_pkg::NUM_CH-1:0] chan_evt_in,
   input  wire logic [2:0]                            clock_pin_in,
   output logic      [timer_pkg::NUM_CH-1:0][15:0]    compare_c_value_out,
   output logic      [timer_pkg::NUM_CH-1:0]          irq_out,
   output logic                                       sync_trigger_out,
   output logic      [2:0]                            ext_clock_out
);
   import timer_pkg::*;

   // ---------------------------------------------
   // Functions
   // ---------------------------------------------

   // Address match for a channel register
   function automatic logic chan_hit(input logic [7:0] a, input int n,
                                     input logic [5:0] ofs);
      return a == {2'(n), ofs};
   endfunction

   // External clock selector
   function automatic logic pick_clock(input logic [1:0] sel, input logic pin,
                                       input logic lo, input logic hi);
      logic r;
      unique case (clk_src_t'(sel))
         SRC_PIN:     r = pin;
         SRC_NONE:    r = 1'b0;
         SRC_LINE_LO: r = lo;
         SRC_LINE_HI: r = hi;
      endcase
      return r;
   endfunction

   // Flags raised by this cycle's events
   function automatic logic [7:0] event_set(input chan_evt_t e,
                                            input logic pa, input logic pb);
      logic [7:0] s;
      logic       cap;
      s   = '0;
      cap = !e.wave_mode;                                   // [RULE21]
      s[BIT_EXT_TRIG] = e.ext_trigger;                      // [RULE6]
      s[BIT_LOAD_B]   = cap & e.load_b;                     // [RULE7]
      s[BIT_LOAD_A]   = cap & e.load_a;                     // [RULE8]
      s[BIT_MATCH_C]  = e.match_c;                          // [RULE9]
      s[BIT_MATCH_B]  = e.wave_mode & e.match_b;            // [RULE10]
      s[BIT_MATCH_A]  = e.wave_mode & e.match_a;            // [RULE11]
      s[BIT_OVERRUN]  = cap & ((e.load_a & pa) | (e.load_b & pb)); // [RULE12]
      s[BIT_WRAP]     = e.wrap;                             // [RULE13]
      return s;
   endfunction

   // ---------------------------------------------
   // Reset release
   // ---------------------------------------------
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   // Two-stage release of the async reset
   always_ff @(posedge mclk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ---------------------------------------------
   // Decode
   // ---------------------------------------------
   logic [NUM_CH-1:0] wr_cmp;
   logic [NUM_CH-1:0] wr_set;
   logic [NUM_CH-1:0] wr_clr;
   logic [NUM_CH-1:0] rd_stat;
   logic [NUM_CH-1:0] rd_cap_a;
   logic [NUM_CH-1:0] rd_cap_b;
   logic              wr_trig;
   logic              wr_route;

   // Per-channel strobes
   always_comb begin
      for (int n = 0; n < NUM_CH; n++) begin
         wr_cmp[n]   = wr_in && chan_hit(addr_in, n, OFS_CMP_C);
         wr_set[n]   = wr_in && chan_hit(addr_in, n, OFS_IRQ_SET);
         wr_clr[n]   = wr_in && chan_hit(addr_in, n, OFS_IRQ_CLR);
         rd_stat[n]  = rd_in && chan_hit(addr_in, n, OFS_STATUS);
         rd_cap_a[n] = rd_in && chan_hit(addr_in, n, OFS_CAP_A);
         rd_cap_b[n] = rd_in && chan_hit(addr_in, n, OFS_CAP_B);
      end
   end

   // Block-wide strobes
   assign wr_trig  = wr_in && (addr_in == OFS_GROUP_TRIG);
   assign wr_route = wr_in && (addr_in == OFS_CLK_ROUTE);

   // ---------------------------------------------
   // Compare C registers
   // ---------------------------------------------
   logic [NUM_CH-1:0][15:0] cmp_c_reg;

   // Software-written compare values
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         cmp_c_reg <= {NUM_CH{CMP_C_RST}};
      end else begin
         for (int n = 0; n < NUM_CH; n++) begin
            if (wr_cmp[n]) begin
               cmp_c_reg[n] <= wdata_in[15:0];               // [RULE1]
            end
         end
      end
   end
   assign compare_c_value_out = cmp_c_reg;

   // ---------------------------------------------
   // Capture pending trackers
   // ---------------------------------------------
   logic [NUM_CH-1:0] pend_a_reg;
   logic [NUM_CH-1:0] pend_b_reg;

   // Load marks pending, register read clears it
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         pend_a_reg <= '0;
         pend_b_reg <= '0;
      end else begin
         for (int n = 0; n < NUM_CH; n++) begin
            pend_a_reg[n] <= chan_evt_in[n].load_a | (pend_a_reg[n] & ~rd_cap_a[n]);
            pend_b_reg[n] <= chan_evt_in[n].load_b | (pend_b_reg[n] & ~rd_cap_b[n]);
         end
      end
   end

   // ---------------------------------------------
   // Event flags
   // ---------------------------------------------
   logic [NUM_CH-1:0][7:0] flags_reg;
   logic [NUM_CH-1:0][7:0] set_vec;

   // Events of this cycle, per channel
   always_comb begin
      for (int n = 0; n < NUM_CH; n++) begin
         set_vec[n] = event_set(chan_evt_in[n],
                                pend_a_reg[n] & ~rd_cap_a[n],
                                pend_b_reg[n] & ~rd_cap_b[n]);
      end
   end

   // Sticky flags; a new event beats the read clear
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         flags_reg <= {NUM_CH{FLAGS_RST}};
      end else begin
         for (int n = 0; n < NUM_CH; n++) begin
            flags_reg[n] <= (rd_stat[n] ? 8'h00 : flags_reg[n]) | set_vec[n]; // [RULE2]
         end
      end
   end

   // ---------------------------------------------
   // Interrupt masks and requests
   // ---------------------------------------------
   logic [NUM_CH-1:0][7:0] mask_reg;
   logic [NUM_CH-1:0]      irq_reg;

   // Set and clear ports of the mask
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= {NUM_CH{MASK_RST}};                     // [RULE16]
      end else begin
         for (int n = 0; n < NUM_CH; n++) begin
            if (wr_set[n]) begin
               mask_reg[n] <= mask_reg[n] | wdata_in[7:0];   // [RULE14]
            end else if (wr_clr[n]) begin
               mask_reg[n] <= mask_reg[n] & ~wdata_in[7:0];  // [RULE15]
            end
         end
      end
   end

   // Request while any enabled flag is pending
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         irq_reg <= '0;
      end else begin
         for (int n = 0; n < NUM_CH; n++) begin
            irq_reg[n] <= |(flags_reg[n] & mask_reg[n]);     // [RULE22]
         end
      end
   end
   assign irq_out = irq_reg;

   // ---------------------------------------------
   // Group trigger and clock routing
   // ---------------------------------------------
   logic       sync_reg;
   logic [5:0] route_reg;
   logic [2:0] xc_reg;

   // One-cycle software trigger to all channels
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_reg <= 1'b0;
      end else begin
         sync_reg <= wr_trig && wdata_in[BIT_SYNC];          // [RULE17]
      end
   end
   assign sync_trigger_out = sync_reg;

   // Selector fields
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         route_reg <= ROUTE_RST;
      end else if (wr_route) begin
         route_reg <= wdata_in[5:0];                         // [RULE23]
      end
   end

   // Routed external clocks
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         xc_reg <= 3'h0;
      end else begin
         xc_reg[2] <= pick_clock(route_reg[XC2_LSB +: 2], clock_pin_in[2],
                                 chan_evt_in[0].line_a, chan_evt_in[1].line_a); // [RULE18]
         xc_reg[1] <= pick_clock(route_reg[XC1_LSB +: 2], clock_pin_in[1],
                                 chan_evt_in[0].line_a, chan_evt_in[2].line_a); // [RULE19]
         xc_reg[0] <= pick_clock(route_reg[XC0_LSB +: 2], clock_pin_in[0],
                                 chan_evt_in[1].line_a, chan_evt_in[2].line_a); // [RULE20]
      end
   end
   assign ext_clock_out = xc_reg;

   // ---------------------------------------------
   // Read path
   // ---------------------------------------------
   logic [31:0] rdata_next;
   logic [31:0] rdata_reg;

   // Read mux; unmapped and write-only read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      for (int n = 0; n < NUM_CH; n++) begin
         if (chan_hit(addr_in, n, OFS_CMP_C)) begin
            rdata_next[15:0] = cmp_c_reg[n];                  // [RULE1]
         end
         if (chan_hit(addr_in, n, OFS_STATUS)) begin
            rdata_next[7:0]          = flags_reg[n];
            rdata_next[BIT_CLOCK_ON] = chan_evt_in[n].clock_on; // [RULE5]
            rdata_next[BIT_LINE_A]   = chan_evt_in[n].line_a;   // [RULE4]
            rdata_next[BIT_LINE_B]   = chan_evt_in[n].line_b;   // [RULE3]
         end
         if (chan_hit(addr_in, n, OFS_IRQ_STATE)) begin
            rdata_next[7:0] = mask_reg[n];                    // [RULE16]
         end
      end
      if (addr_in == OFS_CLK_ROUTE) begin
         rdata_next[5:0] = route_reg;                         // [RULE23]
      end
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rd_in ? rdata_next : 32'h0000_0000;
      end
   end
   assign rdata_out = rdata_reg;

   // ---------------------------------------------
   // Assertions on channel 0 and block logic
   // ---------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rst_n);

   chan_evt_t e0;
   assign e0 = chan_evt_in[0];

   status_clear_a: assert property (
      rd_stat[0] && set_vec[0] == 8'h00 |=> flags_reg[0] == 8'h00) // [RULE2]
      else $error("status read did not clear flags");
   trig_flag_a: assert property (
      e0.ext_trigger |=> flags_reg[0][BIT_EXT_TRIG])         // [RULE6]
      else $error("external trigger flag not set");
   load_b_flag_a: assert property (
      e0.load_b && !e0.wave_mode |=> flags_reg[0][BIT_LOAD_B]) // [RULE7]
      else $error("capture B load flag not set");
   load_a_flag_a: assert property (
      e0.load_a && !e0.wave_mode |=> flags_reg[0][BIT_LOAD_A]) // [RULE8]
      else $error("capture A load flag not set");
   match_c_flag_a: assert property (
      e0.match_c |=> flags_reg[0][BIT_MATCH_C])              // [RULE9]
      else $error("compare C flag not set");
   match_b_mode_a: assert property (
      !rd_stat[0] && !e0.wave_mode && !flags_reg[0][BIT_MATCH_B]
      |=> !flags_reg[0][BIT_MATCH_B])                        // [RULE10]
      else $error("compare B flag set in capture mode");
   match_a_flag_a: assert property (
      e0.match_a && e0.wave_mode |=> flags_reg[0][BIT_MATCH_A]) // [RULE11]
      else $error("compare A flag not set");
   overrun_flag_a: assert property (
      !e0.wave_mode && e0.load_a ##1 !rd_cap_a[0] && !e0.wave_mode && e0.load_a
      |=> flags_reg[0][BIT_OVERRUN])                         // [RULE12]
      else $error("overrun flag not set");
   wrap_hold_a: assert property (
      e0.wrap ##1 !rd_stat[0] [*3] |=> flags_reg[0][BIT_WRAP]) // [RULE13]
      else $error("overflow flag lost before read");
   mask_set_a: assert property (
      wr_set[0] |=> (mask_reg[0] & wdata_in[7:0]) == $past(wdata_in[7:0])
      || mask_reg[0] == ($past(mask_reg[0]) | $past(wdata_in[7:0]))) // [RULE14]
      else $error("enable write did not set mask");
   mask_clr_a: assert property (
      wr_clr[0] |=> mask_reg[0] == ($past(mask_reg[0]) & ~$past(wdata_in[7:0]))) // [RULE15]
      else $error("disable write did not clear mask");
   sync_pulse_a: assert property (
      wr_trig && wdata_in[BIT_SYNC] |=> sync_trigger_out ##1 !sync_trigger_out
      || wr_trig)                                            // [RULE17]
      else $error("group trigger not a one-cycle pulse");
   route_two_a: assert property (
      route_reg[XC2_LSB +: 2] == 2'h1 |=> !ext_clock_out[2]) // [RULE18]
      else $error("disabled clock 2 source not low");
   irq_flag_a: assert property (
      |(flags_reg[0] & mask_reg[0]) |=> irq_out[0])          // [RULE22]
      else $error("interrupt not raised");
   cmp_read_a: assert property (
      rd_in && chan_hit(addr_in, 0, OFS_CMP_C)
      |=> rdata_out == {16'h0000, $past(cmp_c_reg[0])})      // [RULE1]
      else $error("compare C readback wrong");

   overrun_seen_c: cover property (flags_reg[0][BIT_OVERRUN]);
   irq_then_clear_c: cover property (irq_out[0] ##1 rd_stat[0] ##2 !irq_out[0]);
   group_trig_c: cover property (sync_trigger_out);
   route_line_c: cover property (route_reg[XC1_LSB +: 2] == 2'h3);

endmodule // timer_status_irq_block_ctrl

// file: testbench/tb_timer_status_irq_block_ctrl.sv
// Self-checking testbench of the timer register block
`timescale 1ns/100ps
module tb_timer_status_irq_block_ctrl;
   import timer_pkg::*;

   // ---------------------------------------------
   // Signals and instance
   // ---------------------------------------------
   logic                          mclk;
   logic                          resetn;
   logic [7:0]                    addr;
   logic [31:0]                   wdata;
   logic                          wr;
   logic                          rd;
   logic [31:0]                   rdata;
   chan_evt_t [NUM_CH-1:0]        chan_evt;
   logic [2:0]                    clock_pin;
   logic [NUM_CH-1:0][15:0]       cmp_c;
   logic [NUM_CH-1:0]             irq;
   logic                          sync_trig;
   logic [2:0]                    ext_clk;
   int                            failures;
   int                            tests_run;

   // Clock at 25 MHz
   always #20 mclk = ~mclk;

   timer_status_irq_block_ctrl timer_status_irq_block_ctrl_i (
      .mclk_in             (mclk),
      .resetn_in           (resetn),
      .addr_in             (addr),
      .wdata_in            (wdata),
      .wr_in               (wr),
      .rd_in               (rd),
      .rdata_out           (rdata),
      .chan_evt_in         (chan_evt),
      .clock_pin_in        (clock_pin),
      .compare_c_value_out (cmp_c),
      .irq_out             (irq),
      .sync_trigger_out    (sync_trig),
      .ext_clock_out       (ext_clk)
   );

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic finish_test();
      if (failures == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One write cycle, then strobe low
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk);
      wr <= 1'b0;
   endtask

   // One read cycle; data taken in the following cycle
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   // Struct bit of the event feeding status bit k
   function automatic int evbit(input int k);
      case (k)
         2: return 3;
         3: return 2;
         4: return 1;
         5: return 5;
         6: return 4;
         7: return 6;
         default: return 0;
      endcase
   endfunction

   task automatic pulse(input int ch, input int k);
      @(posedge mclk);
      chan_evt[ch][evbit(k)] <= 1'b1;
      @(posedge mclk);
      chan_evt[ch][evbit(k)] <= 1'b0;
   endtask

   function automatic logic pick(input logic [1:0] c, input logic p, input logic lo, input logic hi);
      return (c == 2'h0) ? p : (c == 2'h1) ? 1'b0 : (c == 2'h2) ? lo : hi;
   endfunction

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic test_reset();
      logic [31:0] d;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         reg_rd({2'(ch), OFS_CMP_C}, d);     check(d, 32'h0, "compare reset");
         reg_rd({2'(ch), OFS_STATUS}, d);    check(d, 32'h0, "status reset");
         reg_rd({2'(ch), OFS_IRQ_STATE}, d); check(d, 32'h0, "mask reset");
      end
      reg_rd(OFS_CLK_ROUTE, d);              check(d, 32'h0, "route reset");
   endtask

   task automatic test_compare();
      logic [31:0] d;
      logic [15:0] v;
      for (int ch = 0; ch < NUM_CH; ch++) begin
         reg_wr({2'(ch), OFS_CMP_C}, 32'hA5A50000 | 32'(16'hFFFF - 16'(ch) * 16'h1234));
      end
      reg_wr(8'h30, 32'hFFFFFFFF);
      reg_rd(8'h30, d);                       check(d, 32'h0, "unmapped read");
      for (int ch = 0; ch < NUM_CH; ch++) begin
         v = 16'hFFFF - 16'(ch) * 16'h1234;
         reg_rd({2'(ch), OFS_CMP_C}, d);      check(d, {16'h0, v}, "compare read");
         check({16'h0, cmp_c[ch]}, {16'h0, v}, "compare out");
         @(posedge mclk);
         #1 check(rdata, 32'h0, "read data after its cycle");
      end
   endtask

   task automatic test_live();
      logic [31:0] d;
      for (int v = 0; v < 8; v++) begin
         chan_evt[1].clock_on <= v[0];
         chan_evt[1].line_a   <= v[1];
         chan_evt[1].line_b   <= v[2];
         reg_rd({2'h1, OFS_STATUS}, d);  check(d, 32'(v) << 16, "live bits");
         reg_rd({2'h1, OFS_STATUS}, d);  check(d, 32'(v) << 16, "live kept");
      end
      chan_evt[1].clock_on <= 1'b0;
      chan_evt[1].line_a   <= 1'b0;
      chan_evt[1].line_b   <= 1'b0;
   endtask

   task automatic test_flags();
      logic [31:0] d;
      logic [31:0] exp;
      int          ch;
      for (int w = 0; w < 2; w++) begin
         for (int k = 0; k < 8; k++) begin
            if (k != 1) begin
               ch = k % NUM_CH;
               chan_evt[ch].wave_mode <= w[0];
               pulse(ch, k);
               exp = 32'h1 << k;
               if ((k == 5 || k == 6) && w == 1) exp = 32'h0;
               if ((k == 2 || k == 3) && w == 0) exp = 32'h0;
               reg_rd({2'(ch), OFS_STATUS}, d); check(d, exp, "flag set");
               reg_rd({2'(ch), OFS_STATUS}, d); check(d, 32'h0, "flag clear");
            end
         end
      end
      for (int c = 0; c < NUM_CH; c++) chan_evt[c].wave_mode <= 1'b0;
      // Event in the same cycle as the clearing read survives
      @(posedge mclk);
      rd <= 1'b1;
      addr <= {2'h0, OFS_STATUS};
      chan_evt[0].wrap <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      chan_evt[0].wrap <= 1'b0;
      reg_rd({2'h0, OFS_STATUS}, d);   check(d, 32'h1, "event beside read");
   endtask

   task automatic test_overrun();
      logic [31:0] d;
      pulse(0, 5);
      pulse(0, 5);
      reg_rd({2'h0, OFS_STATUS}, d);   check(d, 32'h22, "double load A");
      reg_rd({2'h0, OFS_CAP_A}, d);    check(d, 32'h0, "capture A read");
      pulse(0, 5);
      reg_rd({2'h0, OFS_STATUS}, d);   check(d, 32'h20, "load after read");
      pulse(1, 6);
      pulse(1, 6);
      reg_rd({2'h1, OFS_STATUS}, d);   check(d, 32'h42, "double load B");
      chan_evt[2].wave_mode <= 1'b1;
      pulse(2, 5);
      pulse(2, 5);
      reg_rd({2'h2, OFS_STATUS}, d);   check(d, 32'h0, "loads in waveform");
      chan_evt[2].wave_mode <= 1'b0;
      reg_rd({2'h2, OFS_CAP_A}, d);
   endtask

   task automatic test_irq();
      logic [31:0] d;
      reg_wr({2'h2, OFS_IRQ_SET}, 32'hFFFFFF01);
      reg_rd({2'h2, OFS_IRQ_STATE}, d); check(d, 32'h01, "mask set");
      reg_wr({2'h2, OFS_IRQ_SET}, 32'h80);
      reg_rd({2'h2, OFS_IRQ_STATE}, d); check(d, 32'h81, "mask set keeps");
      reg_wr({2'h2, OFS_IRQ_CLR}, 32'h01);
      reg_wr({2'h2, OFS_IRQ_CLR}, 32'h00);
      reg_rd({2'h2, OFS_IRQ_STATE}, d); check(d, 32'h80, "mask clear");
      reg_rd({2'h0, OFS_IRQ_STATE}, d); check(d, 32'h00, "other mask");
      pulse(2, 0);
      @(posedge mclk);
      #1 check({29'h0, irq}, 32'h0, "masked event");
      reg_rd({2'h2, OFS_STATUS}, d);
      pulse(2, 7);
      @(posedge mclk);
      #1 check({29'h0, irq}, 32'h4, "enabled event");
      reg_rd({2'h2, OFS_STATUS}, d);    check(d, 32'h80, "trigger flag");
      @(posedge mclk);
      #1 check({29'h0, irq}, 32'h0, "request cleared by read");
      reg_wr({2'h2, OFS_IRQ_CLR}, 32'hFF);
   endtask

   task automatic test_trigger();
      logic [31:0] d;
      reg_wr(OFS_GROUP_TRIG, 32'hFFFFFFFE);
      #1 check({31'h0, sync_trig}, 32'h0, "zero write no trigger");
      @(posedge mclk);
      #1 check({31'h0, sync_trig}, 32'h0, "still no trigger");
      reg_wr(OFS_GROUP_TRIG, 32'h1);
      #1 check({31'h0, sync_trig}, 32'h1, "trigger pulse");
      @(posedge mclk);
      #1 check({31'h0, sync_trig}, 32'h0, "trigger one cycle");
      reg_rd(OFS_GROUP_TRIG, d);        check(d, 32'h0, "trigger reads zero");
   endtask

   task automatic test_route();
      logic [31:0] d;
      logic [1:0]  c0;
      logic [1:0]  c1;
      logic [1:0]  c2;
      logic [2:0]  exp;
      for (int c = 0; c < 4; c++) begin
         c0 = 2'(c);
         c1 = 2'(c + 1);
         c2 = 2'(c + 2);
         reg_wr(OFS_CLK_ROUTE, 32'hFFFFFFC0 | {26'h0, c2, c1, c0});
         reg_rd(OFS_CLK_ROUTE, d); check(d, {26'h0, c2, c1, c0}, "route read");
         for (int p = 0; p < 64; p++) begin
            clock_pin <= 3'(p);
            for (int i = 0; i < NUM_CH; i++) chan_evt[i].line_a <= p[3 + i];
            @(posedge mclk);
            @(posedge mclk);
            exp[0] = pick(c0, p[0], p[4], p[5]);
            exp[1] = pick(c1, p[1], p[3], p[5]);
            exp[2] = pick(c2, p[2], p[3], p[4]);
            #1 check({29'h0, ext_clk}, {29'h0, exp}, "clock routing");
         end
      end
   endtask

   // ---------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------
   initial begin
      mclk      = 1'b0;
      resetn    = 1'b0;
      addr      = 8'h00;
      wdata     = 32'h0;
      wr        = 1'b0;
      rd        = 1'b0;
      chan_evt  = '0;
      clock_pin = 3'h0;
      failures  = 0;
      tests_run = 0;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      test_reset();
      test_compare();
      test_live();
      test_flags();
      test_overrun();
      test_irq();
      test_trigger();
      test_route();
      finish_test();
   end

   // Cuts a hung run short
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      $display("MISMATCH at %0t: run did not complete", $time);
      finish_test();
   end

endmodule // tb_timer_status_irq_block_ctrl
